// ---- src/pwm_timer_pkg.sv ----
// constants and carrier types of the compare/capture timer
// assumes one count clock and plain control ports
//
// What this block does
// - repeat down: reload max at underflow, run on
// - down: new max after next underflow
// - one-shot down: reload max, then stop
// - repeat up/down: zero, max, zero until stopped
// - up phase: max above count kept, below clears count
// - down phase: new max used from zero
// - one-shot up/down: stop at zero going down
// - 2, 4 or 6 circuits, compare (0) or capture (1)
// - compare: count equal to buffer, match and flag
// - max and zero reached set own flags
// - match CC+1 clocks past zero, MAX-CC+1 past max
// - compare value enters buffer per load mode
// - shared pin: wave output or capture input
// - 2-bit capture source and edge selects
// - trigger while counting copies count, sets flag
// - capture over a set flag sets overwrite flag
// - sync capture misses pulses under a clock
// - async capture takes short pulses
// - 3-bit mode: output reaction to match, max, zero
// - pair select uses partner match
// - up: past max to zero, repeat or stop
// - polarity 0 active high, 1 active low
// - request for set enabled flags, clear by 1

package pwm_timer_pkg;

    // ****************
    // counter
    // ****************
    localparam int CNT_W = 16;
    localparam logic [15:0] CNT_ZERO = 16'h0000;
    localparam logic [15:0] CNT_ONE = 16'h0001;
    localparam logic [1:0] MODE_UP = 2'h0;
    localparam logic [1:0] MODE_DOWN = 2'h1;
    localparam logic [1:0] MODE_UPDOWN = 2'h2;

    // ****************
    // compare buffer load points
    // ****************
    localparam logic [2:0] BUF_WRITE = 3'h0;
    localparam logic [2:0] BUF_ZERO = 3'h1;
    localparam logic [2:0] BUF_MAX = 3'h2;
    localparam logic [2:0] BUF_BOTH = 3'h3;
    localparam logic [2:0] BUF_MATCH = 3'h4;

    // ****************
    // capture source and edge
    // ****************
    localparam logic [1:0] SRC_PIN = 2'h0;
    localparam logic [1:0] SRC_SW = 2'h1;
    localparam logic [1:0] SRC_LOW = 2'h2;
    localparam logic [1:0] SRC_HIGH = 2'h3;
    localparam logic [1:0] EDGE_NONE = 2'h0;
    localparam logic [1:0] EDGE_RISE = 2'h1;
    localparam logic [1:0] EDGE_FALL = 2'h2;
    localparam logic [1:0] EDGE_BOTH = 2'h3;

    // ****************
    // wave output generation modes
    // ****************
    localparam logic [2:0] OUT_OFF = 3'h0;
    localparam logic [2:0] OUT_SET = 3'h1;
    localparam logic [2:0] OUT_CLR = 3'h2;
    localparam logic [2:0] OUT_TGL = 3'h3;
    localparam logic [2:0] OUT_SET_ZCLR = 3'h4;
    localparam logic [2:0] OUT_CLR_ZSET = 3'h5;
    localparam logic [2:0] OUT_TGL_MCLR = 3'h6;
    localparam logic [2:0] OUT_SET_MCLR = 3'h7;

    // channel counting setup
    typedef struct packed {
        logic enable;
        logic [1:0] mode;
        logic oneShot;
    } count_ctrl_type;

    // per circuit setup
    typedef struct packed {
        logic ccMode;
        logic [2:0] bufLoad;
        logic [1:0] capSrc;
        logic [1:0] capEdge;
        logic capSync;
        logic [2:0] outMode;
        logic pairMatch;
        logic polarity;
    } cc_ctrl_type;

    // events that steer a wave output
    typedef struct packed {
        logic match;
        logic atMax;
        logic atZero;
    } wave_event_type;

endpackage : pwm_timer_pkg

// ---- src/capture_trigger.sv ----
// trigger pick and edge detector of one capture circuit
// assumes an asynchronous pin and a software level on clk
`timescale 1ns/100ps

module capture_trigger (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // setup
    input pwm_timer_pkg::cc_ctrl_type ctrl,
    // trigger sources
    input wire logic pinIn,
    input wire logic swLevel,
    // selected edge seen
    output logic trig
);
    logic meta_q;
    logic pin_q;
    logic hist0_q;
    logic hist1_q;
    logic src;

    // edge test for the selected direction
    function automatic logic edgeHit(input logic [1:0] sel, input logic now,
                                     input logic prev);
        edgeHit = ((sel == pwm_timer_pkg::EDGE_RISE) && now && !prev)
               || ((sel == pwm_timer_pkg::EDGE_FALL) && !now && prev)
               || ((sel == pwm_timer_pkg::EDGE_BOTH) && (now != prev));
    endfunction : edgeHit

    // two-stage pin synchroniser
    always_ff @(posedge clk) begin
        if (reset) begin
            meta_q <= 1'b0;
            pin_q <= 1'b0;
        end else begin
            meta_q <= pinIn;
            pin_q <= meta_q;
        end
    end

    // source pick
    always_comb begin
        unique case (ctrl.capSrc)
            pwm_timer_pkg::SRC_PIN: src = pin_q;
            pwm_timer_pkg::SRC_SW: src = swLevel;
            pwm_timer_pkg::SRC_LOW: src = 1'b0;
            pwm_timer_pkg::SRC_HIGH: src = 1'b1;
        endcase
    end

    // source history
    always_ff @(posedge clk) begin
        if (reset) begin
            hist0_q <= 1'b0;
            hist1_q <= 1'b0;
        end else begin
            hist0_q <= src;
            hist1_q <= hist0_q;
        end
    end

    // sync wants the new level on two samples, async on one
    assign trig = ctrl.capSync
                ? ((src == hist0_q) && edgeHit(ctrl.capEdge, hist0_q, hist1_q))
                : edgeHit(ctrl.capEdge, src, hist0_q);

endmodule : capture_trigger

// ---- src/wave_out_gen.sv ----
// wave level generator of one compare circuit
// assumes events are one-cycle pulses on clk
`timescale 1ns/100ps

module wave_out_gen (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // setup
    input wire logic enable,
    input wire logic [2:0] mode,
    // events
    input pwm_timer_pkg::wave_event_type ev,
    // active level before polarity
    output logic level_q
);
    // match wins over max and zero
    always_ff @(posedge clk) begin
        if (reset || !enable) begin
            level_q <= 1'b0;
        end else begin
            unique case (mode)
                pwm_timer_pkg::OUT_OFF: level_q <= 1'b0;
                pwm_timer_pkg::OUT_SET: level_q <= level_q | ev.match;
                pwm_timer_pkg::OUT_CLR: level_q <= level_q & ~ev.match;
                pwm_timer_pkg::OUT_TGL: level_q <= level_q ^ ev.match;
                pwm_timer_pkg::OUT_SET_ZCLR:
                    level_q <= ev.match | (level_q & ~ev.atZero);
                pwm_timer_pkg::OUT_CLR_ZSET:
                    level_q <= ~ev.match & (level_q | ev.atZero);
                pwm_timer_pkg::OUT_TGL_MCLR:
                    level_q <= ev.match ? ~level_q : (level_q & ~ev.atMax);
                pwm_timer_pkg::OUT_SET_MCLR:
                    level_q <= ev.match | (level_q & ~ev.atMax);
            endcase
        end
    end

endmodule : wave_out_gen

// ---- src/pwm_timer_compare_capture.sv ----
// one timer channel: counter, compare/capture circuits, flags
// assumes controls come from logic on clk, pins from outside
`timescale 1ns/100ps

module pwm_timer_compare_capture #(
    parameter int NUM_CC = 2
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset,

    // counter control
    input pwm_timer_pkg::count_ctrl_type countCtrl,
    input wire logic runStart,
    input wire logic runStop,
    input wire logic presetCount,
    input wire logic [15:0] maxValue,

    // circuit control
    input pwm_timer_pkg::cc_ctrl_type [NUM_CC-1:0] ccCtrl,
    input wire logic [NUM_CC-1:0] ccWrite,
    input wire logic [NUM_CC-1:0][15:0] ccWriteData,
    input wire logic [NUM_CC-1:0] capSwLevel,

    // flag clear and enable
    input wire logic [NUM_CC-1:0] ccFlagClear,
    input wire logic [NUM_CC-1:0] ovFlagClear,
    input wire logic maxFlagClear,
    input wire logic zeroFlagClear,
    input wire logic [NUM_CC-1:0] ccIrqEn,
    input wire logic [NUM_CC-1:0] ovIrqEn,
    input wire logic maxIrqEn,
    input wire logic zeroIrqEn,

    // shared pins
    input wire logic [NUM_CC-1:0] capInPin,
    output logic [NUM_CC-1:0] waveOutPin_q,
    output logic [NUM_CC-1:0] waveOutOe_q,

    // status
    output logic [15:0] count_q,
    output logic countUp_q,
    output logic running_q,
    output logic [NUM_CC-1:0][15:0] ccReg_q,
    output logic [NUM_CC-1:0] ccFlag_q,
    output logic [NUM_CC-1:0] ovFlag_q,
    output logic maxFlag_q,
    output logic zeroFlag_q,
    output logic irq_q
);

    // ****************
    // helpers
    // ****************

    // sticky flag, set wins over clear
    function automatic logic nextFlag(input logic cur, input logic clr,
                                      input logic set);
        nextFlag = (cur & ~clr) | set;
    endfunction : nextFlag

    // compare buffer load point decode
    function automatic logic bufLoadHit(input logic [2:0] sel,
                                        input logic zero,
                                        input logic max,
                                        input logic match);

        unique case (sel)
            pwm_timer_pkg::BUF_WRITE: bufLoadHit = 1'b1;
            pwm_timer_pkg::BUF_ZERO: bufLoadHit = zero;
            pwm_timer_pkg::BUF_MAX: bufLoadHit = max;
            pwm_timer_pkg::BUF_BOTH: bufLoadHit = zero | max;
            pwm_timer_pkg::BUF_MATCH: bufLoadHit = match;
            default: bufLoadHit = 1'b0;
        endcase
    endfunction : bufLoadHit

    // ****************
    // counter
    // ****************

    logic [15:0] count_d;
    logic countUp_d;
    logic running_d;

    logic atMax;
    logic atZero;

    logic countAtMax;
    logic countAtZero;
    logic countAboveMax;

    assign countAtMax = (count_q == maxValue);

    assign countAtZero = (count_q == pwm_timer_pkg::CNT_ZERO);

    assign countAboveMax = (count_q > maxValue);

    // events while counting
    assign atMax = running_q & countAtMax;
    assign atZero = running_q & countAtZero;

    // next count, direction, run
    always_comb begin
        count_d = count_q;
        countUp_d = countUp_q;
        running_d = running_q;

        if (!countCtrl.enable) begin
            count_d = pwm_timer_pkg::CNT_ZERO;
            countUp_d = 1'b1;
            running_d = 1'b0;
        end else if (presetCount) begin
            if (countCtrl.mode == pwm_timer_pkg::MODE_DOWN) begin
                count_d = maxValue;
                countUp_d = 1'b0;
            end else begin
                count_d = pwm_timer_pkg::CNT_ZERO;
                countUp_d = 1'b1;
            end

            running_d = runStart | (running_q & ~runStop);
        end else begin
            if (runStop) begin
                running_d = 1'b0;
            end else if (runStart) begin
                running_d = 1'b1;
            end

            if (running_q) begin
                unique case (countCtrl.mode)
                    pwm_timer_pkg::MODE_UP: begin
                        countUp_d = 1'b1;

                        if (countAtMax || countAboveMax) begin
                            count_d = pwm_timer_pkg::CNT_ZERO;
                            if (countCtrl.oneShot && !runStart) begin
                                running_d = 1'b0;
                            end
                        end else begin
                            count_d = count_q + pwm_timer_pkg::CNT_ONE;
                        end
                    end

                    pwm_timer_pkg::MODE_DOWN: begin
                        countUp_d = 1'b0;

                        if (countAtZero) begin
                            count_d = maxValue;
                            if (countCtrl.oneShot && !runStart) begin
                                running_d = 1'b0;
                            end
                        end else begin
                            count_d = count_q - pwm_timer_pkg::CNT_ONE;
                        end
                    end

                    default: begin
                        if (countUp_q) begin
                            if (countAboveMax) begin
                                count_d = pwm_timer_pkg::CNT_ZERO;
                            end else if (countAtMax) begin
                                countUp_d = 1'b0;
                                if (!countAtZero) begin
                                    count_d = count_q - pwm_timer_pkg::CNT_ONE;
                                end
                            end else begin
                                count_d = count_q + pwm_timer_pkg::CNT_ONE;
                            end
                        end else if (countAtZero) begin
                            if (countCtrl.oneShot && !runStart) begin
                                running_d = 1'b0;
                            end else begin
                                countUp_d = 1'b1;
                                if (maxValue != pwm_timer_pkg::CNT_ZERO) begin
                                    count_d = pwm_timer_pkg::CNT_ONE;
                                end
                            end
                        end else begin
                            count_d = count_q - pwm_timer_pkg::CNT_ONE;
                        end
                    end
                endcase
            end
        end
    end

    // counter registers
    always_ff @(posedge clk) begin
        if (reset) begin
            count_q <= pwm_timer_pkg::CNT_ZERO;
            countUp_q <= 1'b1;
            running_q <= 1'b0;
        end else begin
            count_q <= count_d;
            countUp_q <= countUp_d;
            running_q <= running_d;
        end
    end

    // ****************
    // compare/capture circuits
    // ****************

    logic [NUM_CC-1:0] match;

    logic [NUM_CC-1:0] capHit;

    logic [NUM_CC-1:0] trig;

    logic [NUM_CC-1:0] waveLevel;

    logic [NUM_CC-1:0][15:0] cmpBuf_q;

    genvar gi;

    generate
        for (gi = 0; gi < NUM_CC; gi++) begin : g_cc
            localparam int PAIR = gi ^ 1;

            logic cmpMode;

            pwm_timer_pkg::wave_event_type ev;

            // mode bit picks compare or capture
            assign cmpMode = ~ccCtrl[gi].ccMode;

            // compare hit, flag one clock later
            assign match[gi] = running_q & cmpMode
                             & (count_q == cmpBuf_q[gi]);

            // trigger on the shared pin
            capture_trigger u_trig (
                .clk(clk),
                .reset(reset),
                .ctrl(ccCtrl[gi]),
                .pinIn(capInPin[gi]),
                .swLevel(capSwLevel[gi]),
                .trig(trig[gi])
            );

            // capture only while counting
            assign capHit[gi] = running_q & ~cmpMode & trig[gi];

            // compare data or captured count
            always_ff @(posedge clk) begin
                if (reset) begin
                    ccReg_q[gi] <= pwm_timer_pkg::CNT_ZERO;
                end else if (capHit[gi]) begin
                    ccReg_q[gi] <= count_q;
                end else if (cmpMode && ccWrite[gi]) begin
                    ccReg_q[gi] <= ccWriteData[gi];
                end
            end

            // compare buffer load
            always_ff @(posedge clk) begin
                if (reset) begin
                    cmpBuf_q[gi] <= pwm_timer_pkg::CNT_ZERO;
                end else if (bufLoadHit(ccCtrl[gi].bufLoad, atZero, atMax,
                                        match[gi])) begin
                    cmpBuf_q[gi] <= ccReg_q[gi];
                end
            end

            // compare and overwrite flags
            always_ff @(posedge clk) begin
                if (reset) begin
                    ccFlag_q[gi] <= 1'b0;
                    ovFlag_q[gi] <= 1'b0;
                end else begin
                    ccFlag_q[gi] <= nextFlag(ccFlag_q[gi], ccFlagClear[gi],
                                             match[gi] | capHit[gi]);

                    ovFlag_q[gi] <= nextFlag(ovFlag_q[gi], ovFlagClear[gi],
                                             capHit[gi] & ccFlag_q[gi]);
                end
            end

            // wave events, own or partner match
            assign ev.match = ccCtrl[gi].pairMatch ? match[PAIR]
                                                   : match[gi];

            assign ev.atMax = atMax;
            assign ev.atZero = atZero;

            wave_out_gen u_wave (
                .clk(clk),
                .reset(reset),
                .enable(cmpMode & countCtrl.enable),
                .mode(ccCtrl[gi].outMode),
                .ev(ev),
                .level_q(waveLevel[gi])
            );

            // shared pin drive
            always_ff @(posedge clk) begin
                if (reset) begin
                    waveOutPin_q[gi] <= 1'b0;
                    waveOutOe_q[gi] <= 1'b0;
                end else begin
                    waveOutPin_q[gi] <= waveLevel[gi] ^ ccCtrl[gi].polarity;

                    waveOutOe_q[gi] <= cmpMode & countCtrl.enable;
                end
            end
        end
    endgenerate

    // ****************
    // channel flags and request
    // ****************

    // max and zero flags
    always_ff @(posedge clk) begin
        if (reset) begin
            maxFlag_q <= 1'b0;
            zeroFlag_q <= 1'b0;
        end else begin
            maxFlag_q <= nextFlag(maxFlag_q, maxFlagClear, atMax);

            zeroFlag_q <= nextFlag(zeroFlag_q, zeroFlagClear, atZero);
        end
    end

    // request from enabled flags
    always_ff @(posedge clk) begin
        if (reset) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= (|(ccFlag_q & ccIrqEn)) | (|(ovFlag_q & ovIrqEn))
                   | (maxFlag_q & maxIrqEn) | (zeroFlag_q & zeroIrqEn);
        end
    end

endmodule : pwm_timer_compare_capture

// ---- test/pwm_timer_monitor.sv ----
// port assertions of the timer channel
// assumes a bind onto the channel top, one clock domain
`timescale 1ns/100ps

module pwm_timer_monitor #(
    parameter int NUM_CC = 2
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // controls
    input pwm_timer_pkg::count_ctrl_type countCtrl,
    input wire logic runStart,
    input wire logic runStop,
    input wire logic presetCount,
    input wire logic [15:0] maxValue,
    input pwm_timer_pkg::cc_ctrl_type [NUM_CC-1:0] ccCtrl,
    input wire logic [NUM_CC-1:0] ccFlagClear,
    input wire logic [NUM_CC-1:0] ccIrqEn,
    input wire logic [NUM_CC-1:0] ovIrqEn,
    input wire logic maxIrqEn,
    input wire logic zeroIrqEn,
    // status
    input wire logic [NUM_CC-1:0] waveOutOe_q,
    input wire logic [15:0] count_q,
    input wire logic countUp_q,
    input wire logic running_q,
    input wire logic [NUM_CC-1:0][15:0] ccReg_q,
    input wire logic [NUM_CC-1:0] ccFlag_q,
    input wire logic [NUM_CC-1:0] ovFlag_q,
    input wire logic maxFlag_q,
    input wire logic zeroFlag_q,
    input wire logic irq_q
);
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    logic steady;
    logic down;
    // counter free to move on this edge
    assign steady = running_q && countCtrl.enable && !runStop && !presetCount;
    assign down = countCtrl.mode == pwm_timer_pkg::MODE_DOWN;
    // ****************
    // counter
    // ****************
    AST_DOWN_STEP: assert property (steady && down && count_q != 16'h0000
        |=> count_q == $past(count_q) - 16'h0001) else $error("down step wrong");
    AST_DOWN_RELOAD: assert property (steady && down && count_q == 16'h0000
        |=> count_q == $past(maxValue)) else $error("reload wrong");
    AST_DOWN_ONESHOT: assert property (steady && down && countCtrl.oneShot
        && count_q == 16'h0000 && !runStart |=> !running_q) else $error("no stop");
    AST_UPDOWN_ONESHOT: assert property (steady && countCtrl.mode[1] && countCtrl.oneShot
        && !countUp_q && count_q == 16'h0001 && !runStart
        |=> count_q == 16'h0000 ##[0:1] !running_q) else $error("updown no stop");
    AST_MAX_FLAG: assert property (steady && count_q == maxValue && $stable(maxValue)
        |=> maxFlag_q) else $error("no max flag");
    // ****************
    // circuits and flags
    // ****************
    AST_MATCH: assert property (running_q && !ccCtrl[0].ccMode && $stable(ccReg_q[0])
        && ccCtrl[0].bufLoad == pwm_timer_pkg::BUF_WRITE && count_q == ccReg_q[0]
        |=> ccFlag_q[0]) else $error("no match flag");
    AST_OVERWRITE: assert property (ccCtrl[1].ccMode && $past(ccCtrl[1].ccMode)
        && $past(ccFlag_q[1]) && $changed(ccReg_q[1]) |-> ovFlag_q[1])
        else $error("no overwrite flag");
    AST_STICKY: assert property (ccFlag_q[0] && !ccFlagClear[0] |=> ccFlag_q[0])
        else $error("flag lost");
    AST_IRQ: assert property (1'b1 |=> irq_q == $past(|(ccFlag_q & ccIrqEn)
        || |(ovFlag_q & ovIrqEn) || (maxFlag_q && maxIrqEn) || (zeroFlag_q && zeroIrqEn)))
        else $error("request wrong");
    AST_CAPTURE_OE: assert property (ccCtrl[1].ccMode |=> !waveOutOe_q[1])
        else $error("pin driven");
endmodule : pwm_timer_monitor

// ---- test/trigger_pin_model.sv ----
// model of the trigger source on the shared pins
// assumes the bench resolves pins from the output enables
`timescale 1ns/100ps

module trigger_pin_model #(
    parameter int NUM_CC = 2
) (
    // clock
    input wire logic clk,
    // design drives the pin while set
    input wire logic [NUM_CC-1:0] pinOe,
    // trigger drive toward the pins
    output logic [NUM_CC-1:0] capDrive
);
    initial capDrive = '0;
    // pulse 10 ns short of cycles periods, high across cycles edges
    task automatic pulse(input int idx, input int cycles);
        @(posedge clk);
        #15;
        capDrive[idx] = !pinOe[idx];
        #(20 * cycles - 10);
        capDrive[idx] = 1'b0;
    endtask : pulse
endmodule : trigger_pin_model

// ---- test/testbench.sv ----
// self-checking bench of the timer channel
// assumes package, design and pin model compiled first
`timescale 1ns/100ps

module testbench;
    logic clk, reset, runStart, runStop, presetCount, maxFlagClear, zeroFlagClear;
    logic maxIrqEn, zeroIrqEn, countUp_q, running_q, maxFlag_q, zeroFlag_q, irq_q;
    pwm_timer_pkg::count_ctrl_type countCtrl;
    pwm_timer_pkg::cc_ctrl_type [1:0] ccCtrl;
    logic [15:0] maxValue, count_q, a;
    logic [1:0] ccWrite, capSwLevel, ccFlagClear, ovFlagClear, ccIrqEn, ovIrqEn, capInPin;
    logic [1:0] waveOutPin_q, waveOutOe_q, ccFlag_q, ovFlag_q, capDrive;
    logic [1:0][15:0] ccWriteData, ccReg_q;
    int nErrors, samplesChecked, hit;
    // shared pin level from both parties
    assign capInPin = (waveOutOe_q & waveOutPin_q) | (~waveOutOe_q & capDrive);
    pwm_timer_compare_capture #(.NUM_CC(2)) pwm_timer_compare_capture_inst (.clk, .reset,
        .countCtrl, .runStart, .runStop, .presetCount, .maxValue, .ccCtrl, .ccWrite,
        .ccWriteData, .capSwLevel, .ccFlagClear, .ovFlagClear, .maxFlagClear, .zeroFlagClear,
        .ccIrqEn, .ovIrqEn, .maxIrqEn, .zeroIrqEn, .capInPin, .waveOutPin_q, .waveOutOe_q,
        .count_q, .countUp_q, .running_q, .ccReg_q, .ccFlag_q, .ovFlag_q, .maxFlag_q,
        .zeroFlag_q, .irq_q);
    trigger_pin_model #(.NUM_CC(2)) trigger_pin_model_inst (.clk, .pinOe(waveOutOe_q),
        .capDrive);
    // clock
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        samplesChecked++;
        if (seen !== exp) begin
            nErrors++;
            $display("BAD %0t seen %h want %h", $time, seen, exp);
        end
    endtask : check
    task automatic printVerdict;
        if (nErrors == 0 && samplesChecked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : printVerdict
    // pin pulse of p cycles, then w falling edges
    task automatic trig(input int p, input int w);
        trigger_pin_model_inst.pulse(1, p);
        repeat (w) @(negedge clk);
    endtask : trig
    // ****************
    // run the counter beside a reference, max m2 from cycle k
    // ****************
    task automatic runRef(input logic [1:0] md, input logic os, input logic [15:0] m1,
                          input logic [15:0] m2, input int k, input int n, output int h);
        logic [15:0] c, mx;
        logic up, run;
        c = (md == pwm_timer_pkg::MODE_DOWN) ? m1 : 16'h0000;
        {up, run, h} = {2'h3, -32'sd1};
        @(negedge clk);
        countCtrl = '{enable: 1'b1, mode: md, oneShot: os};
        {maxValue, presetCount, runStart} = {m1, 2'h3};
        {ccFlagClear, ovFlagClear, maxFlagClear, zeroFlagClear} = 6'h3F;
        @(negedge clk);
        {presetCount, runStart, ccFlagClear, ovFlagClear, maxFlagClear, zeroFlagClear} = '0;
        for (int i = 0; i < n; i++) begin
            mx = (i >= k) ? m2 : m1;
            maxValue = mx;
            check(count_q, c);
            if (h < 0 && ccFlag_q[0] === 1'b1) h = i;
            if (!run) begin
            end else if (md == pwm_timer_pkg::MODE_UP) begin
                run = !(os && c >= mx);
                c = (c >= mx) ? 16'h0000 : c + 16'h0001;
            end else if (md == pwm_timer_pkg::MODE_DOWN) begin
                run = !(os && c == 16'h0000);
                c = (c == 16'h0000) ? mx : c - 16'h0001;
            end else if (up) begin
                up = (c != mx);
                c = (c > mx) ? 16'h0000 : (c == mx) ? c - 16'h0001 : c + 16'h0001;
            end else begin
                up = (c == 16'h0001);
                run = !(os && c == 16'h0001);
                c = c - 16'h0001;
            end
            @(negedge clk);
        end
        check(16'(running_q), 16'(run));
        runStop = 1'b1;
        @(negedge clk);
        runStop = 1'b0;
    endtask : runRef
    // watchdog
    initial begin
        #100000;
        nErrors++;
        printVerdict();
    end
    // main sequence
    initial begin
        {nErrors, samplesChecked} = '0;
        {runStart, runStop, presetCount, maxFlagClear, zeroFlagClear, maxIrqEn} = '0;
        {zeroIrqEn, ccWrite, capSwLevel, ccFlagClear, ovFlagClear, ccIrqEn, ovIrqEn} = '0;
        {countCtrl, ccCtrl, maxValue, ccWriteData} = '0;
        reset = 1'b1;
        repeat (3) @(negedge clk);
        {reset, ccWriteData[0], ccWrite[0]} = {1'b0, 16'h0003, 1'b1};
        @(negedge clk);
        ccWrite[0] = 1'b0;
        runRef(pwm_timer_pkg::MODE_DOWN, 1'b0, 16'h0004, 16'h0006, 2, 14, hit);
        check(16'(hit), 16'h0002);
        runRef(pwm_timer_pkg::MODE_DOWN, 1'b1, 16'h0003, 16'h0003, 0, 8, hit);
        runRef(pwm_timer_pkg::MODE_UPDOWN, 1'b0, 16'h0006, 16'h0002, 4, 16, hit);
        runRef(pwm_timer_pkg::MODE_UPDOWN, 1'b0, 16'h0003, 16'h0005, 5, 16, hit);
        runRef(pwm_timer_pkg::MODE_UPDOWN, 1'b1, 16'h0003, 16'h0003, 0, 10, hit);
        {ccCtrl[0].outMode, ccIrqEn[0]} = {pwm_timer_pkg::OUT_TGL, 1'b1};
        runRef(pwm_timer_pkg::MODE_UP, 1'b1, 16'h0007, 16'h0007, 0, 10, hit);
        check(16'(hit), 16'h0004);
        check({waveOutOe_q[0], waveOutPin_q[0], irq_q, maxFlag_q, zeroFlag_q}, 16'h1F);
        {ccCtrl[0].polarity, ccIrqEn[0]} = 2'h2;
        repeat (3) @(negedge clk);
        check({waveOutPin_q[0], irq_q, ccFlag_q[0]}, 16'h0001);
        {ccCtrl[1].ccMode, ccCtrl[1].capEdge} = {1'b1, pwm_timer_pkg::EDGE_RISE};
        fork
            runRef(pwm_timer_pkg::MODE_UP, 1'b0, 16'h00C8, 16'h00C8, 0, 60, hit);
            begin
                repeat (3) @(negedge clk);
                trig(1, 8);
                a = ccReg_q[1];
                check(16'(ccFlag_q[1]), 16'h0001);
                trig(1, 8);
                check(ccReg_q[1] - a, 16'h0009);
                check(16'(ovFlag_q[1]), 16'h0001);
                {ccCtrl[1].capSync, ccFlagClear[1]} = 2'h3;
                @(negedge clk);
                ccFlagClear[1] = 1'b0;
                trig(1, 6);
                check(16'(ccFlag_q[1]), 16'h0000);
                trig(3, 6);
                check(16'(ccFlag_q[1]), 16'h0001);
                {ccCtrl[1].capSrc, ccFlagClear[1]} = {pwm_timer_pkg::SRC_SW, 1'b1};
                @(negedge clk);
                {ccFlagClear[1], capSwLevel[1]} = 2'h1;
                repeat (5) @(negedge clk);
                check(16'(ccFlag_q[1]), 16'h0001);
            end
        join
        printVerdict();
    end
endmodule : testbench

bind pwm_timer_compare_capture pwm_timer_monitor #(.NUM_CC(NUM_CC)) pwm_timer_monitor_inst (
    .clk, .reset, .countCtrl, .runStart, .runStop, .presetCount, .maxValue, .ccCtrl,
    .ccFlagClear, .ccIrqEn, .ovIrqEn, .maxIrqEn, .zeroIrqEn, .waveOutOe_q, .count_q,
    .countUp_q, .running_q, .ccReg_q, .ccFlag_q, .ovFlag_q, .maxFlag_q, .zeroFlag_q, .irq_q);
